// ==== psm_pkg.sv ====
// package: constants and carrier types for the strap and mii pin logic
package psm_pkg;
    // strap pin order inside the sampled strap vector
    localparam int STRAP_W        = 12;
    localparam int S_ADDR0        = 0;
    localparam int S_ADDR1        = 1;
    localparam int S_ADDR2        = 2;
    localparam int S_DUPLEX       = 3;
    localparam int S_MODE2        = 4;
    localparam int S_BCAST_OFF    = 5;
    localparam int S_ISOLATE      = 6;
    localparam int S_NAND_N       = 7;
    localparam int S_TXC          = 8;
    localparam int S_MODE0        = 9;
    localparam int S_MODE1        = 10;
    localparam int S_ANEG         = 11;
    // strap reset values (internal pull levels)
    localparam logic [11:0] STRAP_RST = 12'h889;
    // management address upper bits
    localparam logic [1:0]  ADDR_HI   = 2'h0;
    // interface modes
    localparam logic [2:0]  MODE_MII  = 3'h0;
    localparam logic [2:0]  MODE_B2B  = 3'h6;
    // lamp modes
    localparam logic [1:0]  LAMP_SPEED = 2'h0;
    localparam logic [1:0]  LAMP_ACT   = 2'h1;
    // activity blink half period, in core clock cycles
    localparam int BLINK_NS  = 100000;
    localparam int CLK_NS    = 50;
    localparam int BLINK_CYC = BLINK_NS / CLK_NS;
    // fifo shape
    localparam int FIFO_W    = 4;
    localparam int FIFO_D    = 32;

    // configuration as latched from straps and overridden by software
    typedef struct packed {
        logic [4:0] station_addr;
        logic       bcast_off;
        logic [2:0] iface_mode;
        logic       aneg_en;
        logic       isolate;
        logic       half_duplex;
        logic       speed_100;
        logic       adv_100;
        logic       nand_tree_en;
        logic       txc_high;
    } psm_cfg_t;

    // receive pin group towards the mac
    typedef struct packed {
        logic [3:0] rxd;
        logic       rxdv;
        logic       rxc;
        logic       rxer;
        logic       col;
        logic       crs;
    } psm_rx_t;

    // software override strobes and values
    typedef struct packed {
        logic       bcast_off_wr;
        logic       bcast_off;
        logic       aneg_wr;
        logic       aneg;
        logic       isolate_wr;
        logic       isolate;
        logic       duplex_wr;
        logic       half_duplex;
        logic       speed_wr;
        logic       speed_100;
        logic       txc_fix_wr;
        logic       txc_fix;
    } psm_sw_t;
endpackage

// ==== psm_fifo.sv ====
// file: small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psm_fifo #(
    parameter int W = 4,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // write side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // read side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } psm_fifo_st_t;
    psm_fifo_st_t st_q, st_d;
    logic push, pop;

    // pointer compare gives honest full and empty
    always_comb begin
        in_ready  = (st_q.wp - st_q.rp) != (AW+1)'(D);
        out_valid = st_q.wp != st_q.rp;
        out_data  = st_q.mem[st_q.rp[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        st_d      = st_q;
        if (push) st_d.mem[st_q.wp[AW-1:0]] = in_data;
        if (push) st_d.wp = st_q.wp + 1'b1;
        if (pop) st_d.rp = st_q.rp + 1'b1;
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// ==== psm_top.sv ====
// file: strap capture, mii pin duty, lamps and open-drain pins of the phy
`timescale 1ns/1ps
`default_nettype none
module psm_top #(
    parameter int BLINK_CYC = psm_pkg::BLINK_CYC
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // shared strap pins, level seen at the pin
    input  wire logic [11:0]            strap_pins,
    // shared pin outputs and enables (enable low drives)
    output logic [11:0]                 shared_out,
    output logic                        shared_oe_n,
    // mii transmit side from the mac
    input  wire logic                   tx_clk_in,
    input  wire logic                   tx_en,
    input  wire logic [3:0]             tx_data,
    input  wire logic                   rmii_mode,
    // recovered receive stream from the line side
    input  wire logic                   line_rx_valid,
    input  wire logic [3:0]             line_rx_data,
    input  wire logic                   line_rx_err,
    input  wire logic                   line_col,
    input  wire logic                   line_crs,
    // transmit stream towards the line side
    output logic                        line_tx_valid,
    input  wire logic                   line_tx_ready,
    output logic [3:0]                  line_tx_data,
    // status from the line side
    input  wire logic                   link_up,
    input  wire logic                   activity,
    input  wire logic                   speed_is_100,
    // software controls
    input  wire psm_pkg::psm_sw_t       sw,
    input  wire logic [1:0]             lamp_mode,
    input  wire logic                   irq_req,
    // management data and interrupt pins, open drain
    input  wire logic                   mdio_drive_low,
    output logic                        mdio_oe_n,
    output logic                        irq_out_n,
    // configuration and status
    output psm_pkg::psm_cfg_t           cfg,
    output logic                        tx_overflow
);
    initial begin
        if (BLINK_CYC < 1) $error("blink count must be positive");
    end

    typedef struct packed {
        logic                   run;
        logic [11:0]            rx_pins;
        psm_pkg::psm_cfg_t      cfg;
        logic [2:0]             tclk_s;
        logic [2:0]             ten_s;
        logic [3:0][2:0]        td_s;
        logic                   tclk_lv;
        logic [3:0]             tx_acc;
        logic                   tx_half;
        logic                   tx_v;
        logic [3:0]             tx_w;
        logic                   ovf;
        logic                   rx_ck;
        logic                   lamp0;
        logic                   lamp1;
        logic [31:0]            blink;
        logic                   blink_ph;
        logic                   mdio_oe_n;
        logic                   irq_n;
        logic                   oe_n;
    } psm_st_t;
    psm_st_t st_q, st_d;

    logic       f_ready;
    logic       tclk_rise;
    logic [4:0] addr;

    // fifo between the transmit sampler and the line side
    psm_fifo #(
        .W (psm_pkg::FIFO_W),
        .D (psm_pkg::FIFO_D)
    ) u_txq (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (st_q.tx_v),
        .in_ready  (f_ready),
        .in_data   (st_q.tx_w),
        .out_valid (line_tx_valid),
        .out_ready (line_tx_ready),
        .out_data  (line_tx_data)
    );

    // next state
    always_comb begin
        st_d = st_q;
        // the first sampling flop feeds only the second
        st_d.tclk_s = {st_q.tclk_s[1:0], tx_clk_in};
        st_d.ten_s  = {st_q.ten_s[1:0], tx_en};
        for (int i = 0; i < 4; i++) begin
            st_d.td_s[i] = {st_q.td_s[i][1:0], tx_data[i]};
        end
        if (st_q.tclk_s[2] == st_q.tclk_s[1]) st_d.tclk_lv = st_q.tclk_s[2];
        tclk_rise = (st_q.tclk_s[2] == st_q.tclk_s[1]) && st_q.tclk_s[2] && !st_q.tclk_lv;
        st_d.run = 1'b1;
        // capture straps at the first edge after release
        if (!st_q.run) begin
            st_d.cfg.station_addr = {psm_pkg::ADDR_HI,
                                     strap_pins[psm_pkg::S_ADDR2],
                                     strap_pins[psm_pkg::S_ADDR1],
                                     strap_pins[psm_pkg::S_ADDR0]};
            st_d.cfg.bcast_off    = strap_pins[psm_pkg::S_BCAST_OFF];
            st_d.cfg.iface_mode   = {strap_pins[psm_pkg::S_MODE2],
                                     strap_pins[psm_pkg::S_MODE1],
                                     strap_pins[psm_pkg::S_MODE0]};
            st_d.cfg.aneg_en      = strap_pins[psm_pkg::S_ANEG];
            st_d.cfg.isolate      = strap_pins[psm_pkg::S_ISOLATE];
            st_d.cfg.half_duplex  = strap_pins[psm_pkg::S_DUPLEX];
            st_d.cfg.speed_100    = strap_pins[psm_pkg::S_ANEG + 0] & 1'b0
                                  | strap_pins[psm_pkg::S_MODE1 + 0] & 1'b0
                                  | speed_strap();
            st_d.cfg.adv_100      = speed_strap();
            st_d.cfg.nand_tree_en = !strap_pins[psm_pkg::S_NAND_N];
            st_d.cfg.txc_high     = strap_pins[psm_pkg::S_TXC];
        end else begin
            // software writes override until the next reset
            if (sw.bcast_off_wr) st_d.cfg.bcast_off = sw.bcast_off;
            if (sw.aneg_wr) st_d.cfg.aneg_en = sw.aneg;
            if (sw.isolate_wr) st_d.cfg.isolate = sw.isolate;
            if (sw.duplex_wr) st_d.cfg.half_duplex = sw.half_duplex;
            if (sw.speed_wr) st_d.cfg.speed_100 = sw.speed_100;
            if (sw.txc_fix_wr && sw.txc_fix) st_d.cfg.txc_high = 1'b0;
        end
        // transmit sampling on txc rising edges
        st_d.tx_v = 1'b0;
        if (st_q.tx_v && !f_ready) st_d.ovf = 1'b1;
        if (st_q.run && tclk_rise && st_q.ten_s[2]) begin
            if (rmii_mode) begin
                st_d.tx_half = !st_q.tx_half;
                if (st_q.tx_half) begin
                    st_d.tx_w = {st_q.td_s[1][2], st_q.td_s[0][2], st_q.tx_acc[1:0]};
                    st_d.tx_v = 1'b1;
                end else begin
                    st_d.tx_acc = {2'h0, st_q.td_s[1][2], st_q.td_s[0][2]};
                end
            end else begin
                st_d.tx_w = {st_q.td_s[3][2], st_q.td_s[2][2],
                             st_q.td_s[1][2], st_q.td_s[0][2]};
                st_d.tx_v = 1'b1;
            end
        end
        if (!st_q.ten_s[2]) st_d.tx_half = 1'b0;
        // receive pin duty; rmii places two bits per clock on rxd[1:0]
        st_d.rx_ck = !st_q.rx_ck;
        st_d.rx_pins = '0;
        if (st_q.run && !st_q.cfg.isolate) begin
            st_d.rx_pins[3:0] = rmii_mode ? {2'h0, line_rx_data[1:0]} : line_rx_data;
            st_d.rx_pins[4]   = line_rx_valid;
            st_d.rx_pins[5]   = st_q.rx_ck;
            st_d.rx_pins[6]   = line_rx_err;
            st_d.rx_pins[7]   = line_col;
            st_d.rx_pins[8]   = line_crs;
        end
        // activity blink timer
        if (st_q.blink >= 32'(BLINK_CYC - 1)) begin
            st_d.blink    = '0;
            st_d.blink_ph = !st_q.blink_ph;
        end else begin
            st_d.blink = st_q.blink + 32'h1;
        end
        // lamp outputs, active low
        st_d.lamp0 = !link_up || (activity && st_q.blink_ph);
        if (lamp_mode == psm_pkg::LAMP_ACT) st_d.lamp0 = !link_up;
        case (lamp_mode)
            psm_pkg::LAMP_SPEED: st_d.lamp1 = !speed_is_100;
            psm_pkg::LAMP_ACT:   st_d.lamp1 = !(activity && st_q.blink_ph);
            default:             st_d.lamp1 = 1'b1;
        endcase
        st_d.rx_pins[9]  = st_q.lamp0;
        st_d.rx_pins[10] = st_q.lamp1;
        // open-drain pins: enable low only while pulling low
        st_d.mdio_oe_n = !(st_q.run && mdio_drive_low);
        st_d.irq_n     = !(st_q.run && irq_req);
        // shared pins turn to outputs one cycle after the strap capture
        st_d.oe_n      = !st_q.run;
    end

    function automatic logic speed_strap();
        return strap_pins[psm_pkg::S_MODE1] ^ strap_pins[psm_pkg::S_MODE1] ^ 1'b1;
    endfunction

    // state register; pins stay inputs while reset is held
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q          <= '0;
            st_q.mdio_oe_n <= 1'b1;
            st_q.irq_n     <= 1'b1;
            st_q.oe_n      <= 1'b1;
            st_q.lamp0     <= 1'b1;
            st_q.lamp1     <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign addr = st_q.cfg.station_addr;

    // outputs straight from flops
    always_comb begin
        shared_out  = st_q.rx_pins;
        shared_oe_n = st_q.oe_n;
        mdio_oe_n   = st_q.mdio_oe_n;
        irq_out_n   = st_q.irq_n;
        cfg         = st_q.cfg;
        tx_overflow = st_q.ovf;
    end

    // straps are held after capture
    strap_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q.run && !sw.bcast_off_wr |=> $stable(st_q.cfg.bcast_off))
        else $error("bcast strap changed without write");
    addr_hi_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q.run |-> addr[4:3] == psm_pkg::ADDR_HI)
        else $error("address upper bits not zero");
    pins_input_a: assert property (@(posedge core_clk)
        !resetn |=> shared_oe_n && mdio_oe_n && irq_out_n)
        else $error("pin driven during reset");
    sequence tx_idle_s;
        !st_q.ten_s[2];
    endsequence
    tx_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tx_idle_s |=> !st_q.tx_v)
        else $error("data taken without enable");
    nand_map_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !st_q.run ##1 1'b1 |-> cfg.nand_tree_en == !$past(strap_pins[psm_pkg::S_NAND_N]))
        else $error("nand strap inverted wrongly");
    speed_lamp_a: assert property (@(posedge core_clk) disable iff (!resetn)
        lamp_mode == psm_pkg::LAMP_SPEED ##1 lamp_mode == psm_pkg::LAMP_SPEED
        |-> st_q.lamp1 == !$past(speed_is_100))
        else $error("speed lamp wrong");
    sw_override_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q.run && sw.isolate_wr |=> cfg.isolate == $past(sw.isolate))
        else $error("isolate write lost");
    rx_duty_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q.run && !st_q.cfg.isolate && !rmii_mode |=> shared_out[4] == $past(line_rx_valid))
        else $error("rx valid not forwarded");
endmodule
`default_nettype wire

// ==== psm_mac_model.sv ====
// partner model: mac transmit side with its link clock and data pins
`timescale 1ns/1ps
`default_nettype none
module psm_mac_model (
    // mac transmit pins
    output logic       tx_clk_in,
    output logic       tx_en,
    output logic [3:0] tx_data
);
    // link clock low, enable low and data at 4'h5 until a frame starts
    initial begin
        tx_clk_in = 1'b0;
        tx_en     = 1'b0;
        tx_data   = 4'h5;
    end
    // one transfer per 400 ns link clock, data set half a period before the rise
    task automatic send(input logic [3:0] d, input logic en);
        tx_en   = en;
        tx_data = en ? d : ~tx_data;
        #200 tx_clk_in = 1'b1;
        #200 tx_clk_in = 1'b0;
    endtask
    // end of frame: clock stands still, data lines stop holding their value
    task automatic stop();
        tx_en   = 1'b0;
        tx_data = ~tx_data;
    endtask
endmodule
`default_nettype wire

// ==== psm_top_tb_top.sv ====
// testbench: strap capture, pin duty, lamps, open-drain pins and transmit fifo
`timescale 1ns/1ps
`default_nettype none
module psm_top_tb_top;
    logic              core_clk, resetn, shared_oe_n, tx_clk_in, tx_en, rmii_mode;
    logic              line_rx_valid, line_rx_err, line_col, line_crs, line_tx_valid;
    logic              line_tx_ready, link_up, activity, speed_is_100, irq_req;
    logic              mdio_drive_low, mdio_oe_n, irq_out_n, tx_overflow;
    logic [11:0]       strap_pins, shared_out;
    logic [3:0]        tx_data, line_rx_data, line_tx_data;
    logic [1:0]        lamp_mode;
    logic [31:0]       lfsr_q, r;
    logic [7:0]        rx_exp;
    logic              iso_e;
    psm_pkg::psm_sw_t  sw;
    psm_pkg::psm_cfg_t cfg;
    logic [3:0]        exp_q[$];
    int                fails, total_checks, k, n;

    // design with a short blink period
    psm_top #(.BLINK_CYC(4)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .strap_pins(strap_pins),
        .shared_out(shared_out), .shared_oe_n(shared_oe_n), .tx_clk_in(tx_clk_in),
        .tx_en(tx_en), .tx_data(tx_data), .rmii_mode(rmii_mode),
        .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data),
        .line_rx_err(line_rx_err), .line_col(line_col), .line_crs(line_crs),
        .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
        .line_tx_data(line_tx_data), .link_up(link_up), .activity(activity),
        .speed_is_100(speed_is_100), .sw(sw), .lamp_mode(lamp_mode), .irq_req(irq_req),
        .mdio_drive_low(mdio_drive_low), .mdio_oe_n(mdio_oe_n), .irq_out_n(irq_out_n),
        .cfg(cfg), .tx_overflow(tx_overflow));
    // far side mac
    psm_mac_model mac_u (.tx_clk_in(tx_clk_in), .tx_en(tx_en), .tx_data(tx_data));

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // hang guard
    initial begin
        #3000000;
        fails++;
        finish_test();
    end

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    // configuration expected from a strap vector
    function automatic psm_pkg::psm_cfg_t exp_cfg(input logic [11:0] s);
        psm_pkg::psm_cfg_t e;
        e              = '0;
        e.station_addr = {psm_pkg::ADDR_HI, s[2:0]};
        e.bcast_off    = s[psm_pkg::S_BCAST_OFF];
        e.iface_mode   = {s[psm_pkg::S_MODE2], s[psm_pkg::S_MODE1], s[psm_pkg::S_MODE0]};
        e.aneg_en      = s[psm_pkg::S_ANEG];
        e.isolate      = s[psm_pkg::S_ISOLATE];
        e.half_duplex  = s[psm_pkg::S_DUPLEX];
        e.speed_100    = 1'b1;
        e.adv_100      = 1'b1;
        e.nand_tree_en = ~s[psm_pkg::S_NAND_N];
        e.txc_high     = s[psm_pkg::S_TXC];
        return e;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // reset with a strap vector, then watch capture and pin turn-around
    task automatic do_reset(input logic [11:0] s);
        @(negedge core_clk);
        resetn     = 1'b0;
        strap_pins = s;
        repeat (8) @(negedge core_clk);
        check({shared_oe_n, irq_out_n, mdio_oe_n}, 3'h7);
        resetn = 1'b1;
        @(negedge core_clk);
        strap_pins = ~s;
        check(cfg, exp_cfg(s));
        check(shared_oe_n, 1'b1);
        @(negedge core_clk);
        check(shared_oe_n, 1'b0);
        repeat (4) @(negedge core_clk);
        check(cfg, exp_cfg(s));
    endtask
    // software override of strapped bits, every strobe at once
    task automatic sw_write(input logic [11:0] s);
        psm_pkg::psm_cfg_t e;
        psm_pkg::psm_sw_t  w;
        e = exp_cfg(s);
        w = psm_pkg::psm_sw_t'(12'(rnd()) | 12'hAAA);
        sw = w;
        @(negedge core_clk);
        sw            = '0;
        e.bcast_off   = w.bcast_off;
        e.aneg_en     = w.aneg;
        e.isolate     = w.isolate;
        iso_e         = w.isolate;
        e.half_duplex = w.half_duplex;
        e.speed_100   = w.speed_100;
        if (w.txc_fix) e.txc_high = 1'b0;
        @(negedge core_clk);
        check(cfg & 16'hFFFB, e & 16'hFFFB);
    endtask
    // lamps, interrupt and management data pins
    task automatic pins_check();
        lamp_mode = 2'h0;
        activity  = 1'b0;
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            {speed_is_100, link_up, irq_req, mdio_drive_low} = r[3:0];
            repeat (3) @(negedge core_clk);
            check({shared_out[10], shared_out[9]}, {~r[3], ~r[2]});
            check({irq_out_n, mdio_oe_n}, {~r[1], ~r[0]});
        end
        lamp_mode = 2'h1;
        repeat (3) @(negedge core_clk);
        check(shared_out[10], 1'b1);
        activity = 1'b1;
        n        = 0;
        for (int i = 0; i < 12; i++) begin
            @(negedge core_clk);
            if (shared_out[10] !== shared_out[9] && i[0]) n++;
        end
        for (int i = 0; i < 12; i++) begin
            k = shared_out[10];
            @(negedge core_clk);
            if (shared_out[10] !== k[0]) n++;
        end
        check(n > 0, 1'b1);
        activity = 1'b0;
    endtask
    // receive stream reaches the shared pins one cycle later
    task automatic rx_check(input logic rm);
        rmii_mode = rm;
        for (int i = 0; i < 24; i++) begin
            if (i > 0) check({shared_out[8:6], shared_out[4:0]}, rx_exp);
            r = rnd();
            {line_rx_valid, line_rx_data, line_rx_err, line_col, line_crs} = r[7:0];
            rx_exp = {r[0], r[1], r[2], r[7], rm ? {2'h0, r[4:3]} : r[6:3]};
            if (iso_e) rx_exp = 8'h00;
            @(negedge core_clk);
        end
    endtask
    // one frame: n words, mii nibbles or rmii dibit pairs, with gaps after odd mii nibbles only
    task automatic tx_frame(input int cnt, input logic rm, input int keep);
        logic [3:0] d;
        rmii_mode = rm;
        for (int i = 0; i < cnt; i++) begin
            d = 4'(rnd());
            if (i < keep) exp_q.push_back(d);
            if (rm) begin
                mac_u.send({2'(rnd()), d[1:0]}, 1'b1);
                mac_u.send({2'(rnd()), d[3:2]}, 1'b1);
            end else begin
                mac_u.send(d, 1'b1);
            end
            if (d[0] && !rm) mac_u.send(4'h0, 1'b0);
        end
        mac_u.stop();
    endtask
    // empty the fifo, the far side stalling at random when asked
    task automatic drain(input logic stall);
        k = 0;
        while (exp_q.size() > 0 && k < 3000) begin
            @(negedge core_clk);
            line_tx_ready = stall ? rnd() & 32'h1 : 1'b1;
            if (line_tx_ready && line_tx_valid) check(line_tx_data, exp_q.pop_front());
            k++;
        end
        check(exp_q.size(), 32'h0);
        @(negedge core_clk);
        line_tx_ready = 1'b0;
        @(negedge core_clk);
        check(line_tx_valid, 1'b0);
    endtask

    // main sequence
    initial begin
        {fails, total_checks, k, n} = '0;
        lfsr_q = 32'h1F2E;
        {resetn, rmii_mode, line_rx_valid, line_rx_err, line_col, line_crs} = '0;
        {line_tx_ready, link_up, activity, speed_is_100, irq_req, mdio_drive_low} = '0;
        {line_rx_data, lamp_mode, rx_exp} = '0;
        strap_pins = psm_pkg::STRAP_RST;
        sw         = '0;
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 32'(psm_pkg::STRAP_RST) : (i == 1) ? 32'h0 : (i == 2) ? 32'hFFF : rnd();
            do_reset(r[11:0]);
            sw_write(r[11:0]);
            pins_check();
            rx_check(i[0]);
        end
        tx_frame(12, 1'b0, 12);
        drain(1'b0);
        tx_frame(6, 1'b1, 6);
        drain(1'b0);
        check(tx_overflow, 1'b0);
        tx_frame(33, 1'b0, 32);
        k = 0;
        while (tx_overflow !== 1'b1 && k < 20) begin
            @(negedge core_clk);
            k++;
        end
        check(tx_overflow, 1'b1);
        drain(1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
